// ==== verilog/mmb_top.sv ====
// module: program counter, vectors, program store and banked data memory
`timescale 1ns/100ps
// Summary of operation
// - program and data memories use separate ports, usable together.
// - program counter is 13 bits; 8K words of 14 bits addressable.
// - only program words 0000h to 07FFh physically exist.
// - fetches above 07FFh wrap onto the implemented words.
// - reset loads the program counter with 0000h.
// - a taken interrupt sends execution to 0004h.
// - two bank-select status bits 6 and 5 pick bank 0 to 3.
// - each bank spans offsets 00h to 7Fh.
// - lowest offsets of every bank are special function registers.
// - offsets above them are general purpose static RAM.
// - high use registers such as status appear in all banks.
// - data reachable directly or through the indirect pointer register.
// - user code may read program memory through a read port.
module mmb_top #(
    parameter int PROG_DEPTH = 2048
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic fetch_en_i,
    input wire mmb_pkg::mmb_pc_op_e pc_op_i,
    input wire logic [12:0] pc_load_i,
    input wire logic int_take_i,
    output logic [12:0] pc_o,
    output logic [13:0] instr_o,
    input wire logic prog_wr_i,
    input wire logic [12:0] prog_waddr_i,
    input wire logic [13:0] prog_wdata_i,
    input wire logic pm_rd_i,
    input wire logic [12:0] pm_addr_i,
    output logic [13:0] pm_data_o,
    output logic pm_valid_o,
    input wire mmb_pkg::mmb_dreq_s dreq_i,
    input wire logic sfr_wr_en_i,
    input wire logic [7:0] sfr_rdata_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output mmb_pkg::mmb_dsel_s sel_o,
    output logic [7:0] status_o,
    output logic [7:0] indirect_pointer_reg_o,
    output logic [1:0] bank_select_o
);
    // ------------------------------------------------------------
    // program store
    // ------------------------------------------------------------
    logic [13:0] prog_mem [PROG_DEPTH];
    logic [12:0] pc;
    logic [12:0] next_pc;
    logic [13:0] instr;
    logic [13:0] pm_data;
    logic [13:0] next_pm_data;
    logic pm_valid;

    function automatic logic [10:0] wrap_addr(input logic [12:0] a);
        return a[mmb_pkg::IMPL_AW-1:0]; // upper bits dropped, no error
    endfunction

    always_comb begin
        case (pc_op_i)
            mmb_pkg::MMB_PC_INC: next_pc = pc + 13'h0001;
            mmb_pkg::MMB_PC_LOAD: next_pc = pc_load_i;
            mmb_pkg::MMB_PC_HOLD: next_pc = pc;
            default: next_pc = pc;
        endcase
        if (!fetch_en_i) begin
            next_pc = pc;
        end
        if (int_take_i) begin
            next_pc = mmb_pkg::INT_VEC;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pc <= mmb_pkg::RESET_VEC;
        end else begin
            pc <= next_pc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (prog_wr_i) begin
            prog_mem[wrap_addr(prog_waddr_i)] <= prog_wdata_i;
        end
    end

    // user read port, independent of the fetch path
    always_comb begin
        next_pm_data = pm_data;
        if (pm_rd_i) begin
            next_pm_data = prog_mem[wrap_addr(pm_addr_i)];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            instr <= 14'h0000;
            pm_data <= 14'h0000;
            pm_valid <= 1'b0;
        end else begin
            instr <= prog_mem[wrap_addr(pc)];
            pm_valid <= pm_rd_i;
            pm_data <= next_pm_data;
        end
    end

    assign pc_o = pc;
    assign instr_o = instr;
    assign pm_data_o = pm_data;
    assign pm_valid_o = pm_valid;

    // ------------------------------------------------------------
    // core registers and data decode
    // ------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] next_status;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    mmb_pkg::mmb_dsel_s sel;
    mmb_pkg::mmb_dsel_s sel_q;
    logic [6:0] gpr_idx;
    logic [7:0] gpr_mem [mmb_pkg::GPR_DEPTH];
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic rvalid;
    logic [1:0] bsel;

    assign bsel = {status[mmb_pkg::BSEL_HI_POS], status[mmb_pkg::BSEL_LO_POS]};

    mmb_data_decode mmb_data_decode_i (
        .bank_select_i(bsel),
        .irp_i(status[mmb_pkg::BSEL_IND_POS]),
        .indirect_pointer_reg_i(ptr),
        .req_i(dreq_i),
        .sel_o(sel),
        .gpr_idx_o(gpr_idx)
    );

    always_comb begin
        next_status = status;
        next_ptr = ptr;
        if (dreq_i.req && dreq_i.wr && sfr_wr_en_i && sel.is_sfr) begin
            // status and pointer answer in every bank
            if (sel.sfr_ofs == mmb_pkg::STATUS_OFS) begin
                next_status = dreq_i.wdata;
            end
            if (sel.sfr_ofs == mmb_pkg::PTR_OFS) begin
                next_ptr = dreq_i.wdata;
            end
        end
    end

    // read mux: ram above the sfr area, core regs local, the rest from outside
    always_comb begin
        next_rdata = rdata;
        if (dreq_i.req && !sel.is_sfr) begin
            next_rdata = gpr_mem[gpr_idx];
        end else if (dreq_i.req && sel.sfr_ofs == mmb_pkg::STATUS_OFS) begin
            next_rdata = status;
        end else if (dreq_i.req && sel.sfr_ofs == mmb_pkg::PTR_OFS) begin
            next_rdata = ptr;
        end else if (dreq_i.req) begin
            next_rdata = sfr_rdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status <= mmb_pkg::STATUS_RST;
            ptr <= 8'h00;
            rdata <= 8'h00;
            rvalid <= 1'b0;
            sel_q <= '0;
        end else begin
            status <= next_status;
            ptr <= next_ptr;
            rdata <= next_rdata;
            rvalid <= dreq_i.req;
            sel_q <= sel;
        end
    end

    always_ff @(posedge clk_i) begin
        if (dreq_i.req && dreq_i.wr && !sel.is_sfr) begin
            gpr_mem[gpr_idx] <= dreq_i.wdata;
        end
    end

    assign rdata_o = rdata;
    assign rvalid_o = rvalid;
    assign sel_o = sel_q;
    assign status_o = status;
    assign indirect_pointer_reg_o = ptr;
    assign bank_select_o = bsel;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_int_vector_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        int_take_i |=> pc_o == 13'h0004) else $error("interrupt did not vector to 0004h");
    a_pc_hold_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !fetch_en_i && !int_take_i |=> $stable(pc_o)) else $error("pc moved while idle");
    a_pc_increment: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        fetch_en_i && !int_take_i && pc_op_i == mmb_pkg::MMB_PC_INC
        |=> pc_o == 13'($past(pc_o) + 13'h0001)) else $error("pc increment wrong");
    a_pc_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        fetch_en_i && !int_take_i && pc_op_i == mmb_pkg::MMB_PC_LOAD
        |=> pc_o == $past(pc_load_i)) else $error("pc load wrong");
    a_bank_from_status: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        dreq_i.req && !dreq_i.indirect |=> sel_o.bank
            == $past(status_o[mmb_pkg::BSEL_HI_POS:mmb_pkg::BSEL_LO_POS]))
        else $error("bank not taken from status bank bits");
    a_direct_address: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        dreq_i.req && !dreq_i.indirect
        |=> sel_o.addr == {$past(bank_select_o), $past(dreq_i.ofs)}) else $error("direct addr wrong");
    a_indirect_address: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        dreq_i.req && dreq_i.indirect |=> sel_o.addr
            == {$past(status_o[mmb_pkg::BSEL_IND_POS]), $past(indirect_pointer_reg_o)})
        else $error("indirect addr wrong");
    a_sfr_low_ofs: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        dreq_i.req |=> sel_o.is_sfr == (sel_o.addr[6:0] <= 7'h1F)) else $error("sfr split wrong");
    a_pm_read_valid: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        pm_rd_i |=> pm_valid_o ##1 (pm_valid_o == $past(pm_rd_i))) else $error("pm read valid");
    a_status_mirror: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        dreq_i.req && dreq_i.wr && sfr_wr_en_i && !dreq_i.indirect && dreq_i.ofs == 7'h03
        |=> status_o == $past(dreq_i.wdata)) else $error("status write missed in a bank");
endmodule

// ==== verilog/mmb_pkg.sv ====
// package: constants and carriers for the memory map and bank decode block
package mmb_pkg;
    localparam int PC_W = 13;
    localparam int WORD_W = 14;
    localparam int IMPL_AW = 11;
    localparam logic [12:0] RESET_VEC = 13'h0000;
    localparam logic [12:0] INT_VEC = 13'h0004;
    localparam int DA_W = 9;
    localparam int OFS_W = 7;
    localparam logic [6:0] OFS_MAX = 7'h7F;
    localparam int BSEL_HI_POS = 6;
    localparam int BSEL_LO_POS = 5;
    localparam int BSEL_IND_POS = 7;
    localparam logic [6:0] SFR_END = 7'h1F;
    localparam logic [6:0] COMMON_LO = 7'h70;
    localparam logic [6:0] IND_OFS = 7'h00;
    localparam logic [6:0] PCL_OFS = 7'h02;
    localparam logic [6:0] STATUS_OFS = 7'h03;
    localparam logic [6:0] PTR_OFS = 7'h04;
    localparam logic [6:0] PCLATH_OFS = 7'h0A;
    localparam logic [6:0] INTCON_OFS = 7'h0B;
    localparam int GPR_DEPTH = 128;
    localparam logic [7:0] STATUS_RST = 8'h18;

    typedef enum logic [1:0] {
        MMB_PC_INC,
        MMB_PC_LOAD,
        MMB_PC_HOLD
    } mmb_pc_op_e;

    typedef struct packed {
        logic req;
        logic indirect;
        logic [6:0] ofs;
        logic wr;
        logic [7:0] wdata;
    } mmb_dreq_s;

    typedef struct packed {
        logic is_sfr;
        logic [6:0] sfr_ofs;
        logic [1:0] bank;
        logic [8:0] addr;
    } mmb_dsel_s;
endpackage

// ==== verilog/mmb_data_decode.sv ====
// module: banked data address decode, direct and indirect
`timescale 1ns/100ps
module mmb_data_decode (
    input wire logic [1:0] bank_select_i,
    input wire logic irp_i,
    input wire logic [7:0] indirect_pointer_reg_i,
    input wire mmb_pkg::mmb_dreq_s req_i,
    output mmb_pkg::mmb_dsel_s sel_o,
    output logic [6:0] gpr_idx_o
);
    // ------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------
    function automatic logic [6:0] fold_gpr(input logic [6:0] ofs);
        // all banks alias onto one shared ram, so only the offset counts
        return ofs;
    endfunction

    logic [8:0] addr;
    logic [6:0] ofs;
    always_comb begin
        if (req_i.indirect) begin
            addr = {irp_i, indirect_pointer_reg_i};
        end else begin
            addr = {bank_select_i, req_i.ofs};
        end
        ofs = addr[6:0] & mmb_pkg::OFS_MAX;
        sel_o.addr = addr;
        sel_o.bank = addr[8:7];
        sel_o.is_sfr = (ofs <= mmb_pkg::SFR_END);
        sel_o.sfr_ofs = ofs;
        gpr_idx_o = fold_gpr(ofs);
    end
endmodule

// ==== testbench/mmb_sfr_model.sv ====
// file: stand-in for the peripheral register read path of the core
`timescale 1ns/100ps
module mmb_sfr_model (
    input wire logic [6:0] ofs_i,
    output logic [7:0] rdata_o
);
    // unique pattern per offset so a wrong decode shows up
    assign rdata_o = {1'b1, ofs_i};
endmodule

// ==== testbench/memory_map_bank_decode_test.sv ====
// file: self-checking bench for the memory map and bank decode block
`timescale 1ns/100ps
module memory_map_bank_decode_test;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic fetch_en_i = 1'b0;
    mmb_pkg::mmb_pc_op_e pc_op_i = mmb_pkg::MMB_PC_HOLD;
    logic [12:0] pc_load_i = 13'h0000;
    logic int_take_i = 1'b0;
    logic prog_wr_i = 1'b0;
    logic [12:0] prog_waddr_i = 13'h0000;
    logic [13:0] prog_wdata_i = 14'h0000;
    logic pm_rd_i = 1'b0;
    logic [12:0] pm_addr_i = 13'h0000;
    mmb_pkg::mmb_dreq_s dreq_i = '0;
    logic sfr_wr_en_i = 1'b0;
    logic [7:0] sfr_rdata_i;
    logic [12:0] pc_o;
    logic [13:0] instr_o;
    logic [13:0] pm_data_o;
    logic pm_valid_o;
    logic [7:0] rdata_o;
    logic rvalid_o;
    mmb_pkg::mmb_dsel_s sel_o;
    logic [7:0] status_o;
    logic [7:0] indirect_pointer_reg_o;
    logic [1:0] bank_select_o;
    int n_mismatch = 0;
    int check_count = 0;

    always #2 clk_i = ~clk_i;

    mmb_top #(.PROG_DEPTH(2048)) mmb_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .fetch_en_i(fetch_en_i), .pc_op_i(pc_op_i), .pc_load_i(pc_load_i),
        .int_take_i(int_take_i), .pc_o(pc_o), .instr_o(instr_o), .prog_wr_i(prog_wr_i),
        .prog_waddr_i(prog_waddr_i), .prog_wdata_i(prog_wdata_i), .pm_rd_i(pm_rd_i),
        .pm_addr_i(pm_addr_i), .pm_data_o(pm_data_o), .pm_valid_o(pm_valid_o),
        .dreq_i(dreq_i), .sfr_wr_en_i(sfr_wr_en_i), .sfr_rdata_i(sfr_rdata_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sel_o(sel_o), .status_o(status_o),
        .indirect_pointer_reg_o(indirect_pointer_reg_o), .bank_select_o(bank_select_o));

    mmb_sfr_model mmb_sfr_model_i (.ofs_i(dreq_i.ofs), .rdata_o(sfr_rdata_i));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one data access; returns in the cycle where the answer stands
    task automatic dacc(input logic ind, input logic [6:0] ofs, input logic wr,
                        input logic [7:0] wd);
        @(negedge clk_i);
        dreq_i = '{1'b1, ind, ofs, wr, wd};
        @(negedge clk_i);
        dreq_i.req = 1'b0;
        chk(rvalid_o, 1'b1);
    endtask

    task automatic pcop(input mmb_pkg::mmb_pc_op_e op, input logic [12:0] v,
                        input logic it);
        @(negedge clk_i);
        fetch_en_i = 1'b1;
        pc_op_i = op;
        pc_load_i = v;
        int_take_i = it;
        @(negedge clk_i);
        fetch_en_i = 1'b0;
        int_take_i = 1'b0;
        pc_op_i = mmb_pkg::MMB_PC_HOLD;
    endtask

    task automatic pwr(input logic [12:0] a, input logic [13:0] d);
        @(negedge clk_i);
        prog_wr_i = 1'b1;
        prog_waddr_i = a;
        prog_wdata_i = d;
        @(negedge clk_i);
        prog_wr_i = 1'b0;
    endtask

    task automatic pmr(input logic [12:0] a, input logic [13:0] exp);
        @(negedge clk_i);
        pm_rd_i = 1'b1;
        pm_addr_i = a;
        @(negedge clk_i);
        pm_rd_i = 1'b0;
        chk(pm_valid_o, 1'b1);
        chk(pm_data_o, exp);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk(pc_o, 13'h0000);
        chk(status_o, 8'h18);
        chk(bank_select_o, 2'b00);
        chk(indirect_pointer_reg_o, 8'h00);
    endtask

    task automatic t_prog();
        pwr(13'h0010, 14'h2ABC);
        pwr(13'h07FF, 14'h1234);
        pmr(13'h0810, 14'h2ABC);
        pmr(13'h07FF, 14'h1234);
        @(negedge clk_i);
        chk(pm_valid_o, 1'b0);
    endtask

    task automatic t_pc();
        pcop(mmb_pkg::MMB_PC_LOAD, 13'h1FFF, 1'b0);
        chk(pc_o, 13'h1FFF);
        @(negedge clk_i);
        chk(instr_o, 14'h1234);
        pcop(mmb_pkg::MMB_PC_INC, 13'h0000, 1'b0);
        chk(pc_o, 13'h0000);
        pcop(mmb_pkg::MMB_PC_LOAD, 13'h0810, 1'b1);
        chk(pc_o, 13'h0004);
        pcop(mmb_pkg::MMB_PC_LOAD, 13'h0810, 1'b0);
        @(negedge clk_i);
        chk(instr_o, 14'h2ABC);
    endtask

    task automatic t_bank();
        logic [1:0] b;
        dacc(1'b0, mmb_pkg::STATUS_OFS, 1'b1, 8'h78);
        chk(status_o, 8'h18);
        sfr_wr_en_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            b = i[1:0];
            dacc(1'b0, mmb_pkg::STATUS_OFS, 1'b1, {1'b0, b, 5'h18});
            chk(bank_select_o, b);
            dacc(1'b0, 7'h7F, 1'b1, {6'h00, b});
            chk(sel_o.addr, {b, 7'h7F});
            chk(sel_o.is_sfr, 1'b0);
            dacc(1'b0, mmb_pkg::STATUS_OFS, 1'b0, 8'h00);
            chk(rdata_o, {1'b0, b, 5'h18});
            dacc(1'b0, 7'h1F, 1'b0, 8'h00);
            chk(sel_o.is_sfr, 1'b1);
            chk(sel_o.sfr_ofs, 7'h1F);
            chk(rdata_o, 8'h9F);
            chk(sel_o.bank, b);
        end
        dacc(1'b0, 7'h7F, 1'b0, 8'h00);
        chk(rdata_o, 8'h03);
    endtask

    task automatic t_ind();
        dacc(1'b0, mmb_pkg::STATUS_OFS, 1'b1, 8'h18);
        dacc(1'b0, 7'h25, 1'b1, 8'h5A);
        dacc(1'b0, mmb_pkg::PTR_OFS, 1'b1, 8'hA5);
        chk(indirect_pointer_reg_o, 8'hA5);
        // program read alongside the data access
        pm_rd_i = 1'b1;
        pm_addr_i = 13'h0010;
        dacc(1'b1, 7'h00, 1'b0, 8'h00);
        pm_rd_i = 1'b0;
        chk(rdata_o, 8'h5A);
        chk(sel_o.addr, 9'h0A5);
        chk(pm_data_o, 14'h2ABC);
        // status bit 7 supplies the ninth bit of an indirect address
        dacc(1'b0, mmb_pkg::STATUS_OFS, 1'b1, 8'h98);
        dacc(1'b1, 7'h00, 1'b0, 8'h00);
        chk(sel_o.addr, 9'h1A5);
        chk(rdata_o, 8'h5A);
    endtask

    initial begin
        repeat (6) @(negedge clk_i);
        arst_n_i = 1'b1;
        t_reset();
        t_prog();
        t_pc();
        t_bank();
        t_ind();
        wrap_up();
    end

    initial begin
        #40000;
        n_mismatch++;
        wrap_up();
    end
endmodule
